// File: src/eif_pkg.sv
// package: register map, field positions and codes for the external interrupt filter
package eif_pkg;
  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_MODE = 8'h04;
  localparam logic [7:0] OFS_CFG1 = 8'h08;
  localparam logic [7:0] OFS_CFG2 = 8'h0C;
  localparam logic [7:0] OFS_CFG3 = 8'h10;
  localparam logic [7:0] OFS_CFG4 = 8'h14;
  localparam logic [7:0] OFS_STAT = 8'h18;
  // ==========================================================================
  // control register fields
  localparam int CTRL_GATE_BIT = 0;
  localparam int CTRL_MASTER_BIT = 1;
  localparam int CTRL_EN_LSB = 8;
  // ==========================================================================
  // per-source config fields
  localparam int CFG_NC_LSB = 0;
  localparam int CFG_ES_LSB = 2;
  localparam int CFG_LVL_BIT = 4;
  // ==========================================================================
  // status fields
  localparam int STAT_FILT_LSB = 0;
  // ==========================================================================
  // reset values
  localparam logic [1:0] NC_RESET = 2'h0;
  localparam logic [1:0] ES_RESET = 2'h0;
  localparam logic [5:0] EN_RESET = 6'h00;
  // ==========================================================================
  // trigger select codes
  localparam logic [1:0] ES_RISE = 2'h0;
  localparam logic [1:0] ES_FALL = 2'h1;
  localparam logic [1:0] ES_BOTH = 2'h2;
  localparam logic [1:0] ES_HIGH = 2'h3;
  // ==========================================================================
  // sampling interval codes and prescaler masks
  localparam logic [1:0] NC_DIV1 = 2'h0;
  localparam logic [1:0] NC_DIV4 = 2'h1;
  localparam logic [1:0] NC_DIV8 = 2'h2;
  localparam logic [1:0] NC_DIV16 = 2'h3;
  localparam logic [3:0] PRE_MASK4 = 4'h3;
  localparam logic [3:0] PRE_MASK8 = 4'h7;
  localparam logic [3:0] PRE_MASK16 = 4'hF;
  // ==========================================================================
  // slow mode: low-frequency clock divided by 4
  localparam logic [1:0] SLOW_DIV_LAST = 2'h3;
  // ==========================================================================
  // operating modes
  typedef enum logic [1:0] {
    EIF_FAST = 2'b00,
    EIF_SLOW = 2'b01,
    EIF_HALT = 2'b10
  } eif_mode_t;
  localparam int NUM_SRC = 6;
endpackage

// File: src/eif_top.sv
// module: six-pin external interrupt noise filter and trigger detector with wishbone registers
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`default_nettype none
// Behaviour
// R1: only sources one to four have programmable trigger and filter timing
// R2: source zero requests on filtered falling edge of its active-low pin
// R3: fast fixed sources reject under one clock, accept two clocks
// R4: slow mode rejects under four low-freq periods, accepts eight
// R5: sources one to three: 00 rise, 01 fall, 10 both, 11 reserved
// R6: source four also offers a high-level trigger
// R7: each configurable request captures the filtered level in a readable bit
// R8: fast configurable filter accepts a level after three equal samples
// R9: fast configurable reject under two intervals, accept over three plus one
// R10: a request passes only with master and source enable set
// R11: gate bit zero stops the logic; one runs it
// R12: reset clears the gate bit
// R13: software sets the gate bit before touching source configuration
// R14: a gate change may produce a spurious request
// R15: software disables a source before gate or mode changes and waits
// R16: interval code selects clock divided by 1, 4, 8 or 16
// R17: slow mode samples at low-freq divided by four, two equal samples
// R18: halted modes stop sampling and requests until run resumes
// R19: captured level reads zero after reset, refreshed on every request
// R20: each pin passes a two-flop synchroniser before the filter
// R21: filtered levels start low at reset
module eif_top #(
  parameter int LF_DIV = 7629
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic ext_irq_pin_zero_n_i,
  input wire logic ext_irq_pin_one_i,
  input wire logic ext_irq_pin_two_i,
  input wire logic ext_irq_pin_three_i,
  input wire logic ext_irq_pin_four_i,
  input wire logic ext_irq_pin_five_i,
  output logic [5:0] irq_req_o
);
  localparam int N = eif_pkg::NUM_SRC;
  localparam int LFW = $clog2(LF_DIV + 1);

  // ==========================================================================
  // registers
  logic ext_irq_clock_gate_reg;
  logic master_irq_enable_reg;
  logic [N-1:0] enable_reg;
  logic [1:0] mode_reg;
  logic [1:0] nc_reg [N];
  logic [1:0] es_reg [N];
  logic [N-1:0] captured_level_reg;
  logic ack_reg;
  logic [31:0] rdata_reg;
  logic [5:0] irq_req_reg;
  logic [N-1:0] sync1_reg;
  logic [N-1:0] sync2_reg;
  logic [N-1:0] filt_reg;
  logic [N-1:0] prev_reg;
  logic [3:0] pre_reg;
  logic [LFW-1:0] lf_reg;
  logic [1:0] slow_div_reg;
  logic slow_tick;
  logic run;
  logic fast;
  logic [N-1:0] tick;
  logic [N-1:0] ev;
  logic [N-1:0] pins;
  logic wr_en;
  logic rd_en;

  assign pins = {ext_irq_pin_five_i, ext_irq_pin_four_i, ext_irq_pin_three_i,
                 ext_irq_pin_two_i, ext_irq_pin_one_i, ext_irq_pin_zero_n_i};
  assign run = ext_irq_clock_gate_reg && (mode_reg == eif_pkg::EIF_FAST || mode_reg == eif_pkg::EIF_SLOW); // [R11] [R18]
  assign fast = mode_reg == eif_pkg::EIF_FAST;
  assign wr_en = wb_cyc_i && wb_stb_i && wb_we_i && ack_reg;
  assign rd_en = wb_cyc_i && wb_stb_i && !ack_reg;

  // ==========================================================================
  // wishbone handshake
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= wb_cyc_i && wb_stb_i && !ack_reg;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdata_reg <= 32'h0000_0000;
    end else if (rd_en) begin
      rdata_reg <= 32'h0000_0000;
      unique case (wb_adr_i)
        eif_pkg::OFS_CTRL: begin
          rdata_reg[eif_pkg::CTRL_GATE_BIT] <= ext_irq_clock_gate_reg;
          rdata_reg[eif_pkg::CTRL_MASTER_BIT] <= master_irq_enable_reg;
          rdata_reg[eif_pkg::CTRL_EN_LSB +: N] <= enable_reg;
        end
        eif_pkg::OFS_MODE: rdata_reg[1:0] <= mode_reg;
        eif_pkg::OFS_CFG1, eif_pkg::OFS_CFG2, eif_pkg::OFS_CFG3, eif_pkg::OFS_CFG4: begin
          for (int k = 1; k <= 4; k++) begin
            if (wb_adr_i == eif_pkg::OFS_CFG1 + 8'(4 * (k - 1))) begin
              rdata_reg[eif_pkg::CFG_NC_LSB +: 2] <= nc_reg[k];
              rdata_reg[eif_pkg::CFG_ES_LSB +: 2] <= es_reg[k];
              rdata_reg[eif_pkg::CFG_LVL_BIT] <= captured_level_reg[k]; // [R7]
            end
          end
        end
        eif_pkg::OFS_STAT: rdata_reg[eif_pkg::STAT_FILT_LSB +: N] <= filt_reg;
        default: rdata_reg <= 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // control and mode registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_clock_gate_reg <= 1'b0; // [R12]
      master_irq_enable_reg <= 1'b0;
      enable_reg <= eif_pkg::EN_RESET;
      mode_reg <= eif_pkg::EIF_FAST;
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == eif_pkg::OFS_CTRL) begin
      ext_irq_clock_gate_reg <= wb_dat_i[eif_pkg::CTRL_GATE_BIT];
      master_irq_enable_reg <= wb_dat_i[eif_pkg::CTRL_MASTER_BIT];
      if (wb_sel_i[1]) begin
        enable_reg <= wb_dat_i[eif_pkg::CTRL_EN_LSB +: N];
      end
    end else if (wr_en && wb_sel_i[1] && wb_adr_i == eif_pkg::OFS_CTRL) begin
      enable_reg <= wb_dat_i[eif_pkg::CTRL_EN_LSB +: N];
    end else if (wr_en && wb_sel_i[0] && wb_adr_i == eif_pkg::OFS_MODE) begin
      mode_reg <= wb_dat_i[1:0];
    end
  end

  // ==========================================================================
  // synchroniser
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= pins; // [R20]
      sync2_reg <= sync1_reg;
    end
  end

  // ==========================================================================
  // prescalers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pre_reg <= 4'h0;
    end else if (run) begin
      pre_reg <= pre_reg + 4'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      lf_reg <= '0;
      slow_div_reg <= 2'h0;
      slow_tick <= 1'b0;
    end else begin
      slow_tick <= 1'b0;
      if (lf_reg == LFW'(LF_DIV - 1)) begin
        lf_reg <= '0;
        slow_div_reg <= slow_div_reg + 2'h1;
        slow_tick <= slow_div_reg == eif_pkg::SLOW_DIV_LAST; // [R17]
      end else begin
        lf_reg <= lf_reg + LFW'(1);
      end
    end
  end

  // ==========================================================================
  // per-source filter and trigger
  generate
    for (genvar i = 0; i < N; i++) begin : gen_src
      localparam bit FIXED = (i == 0) || (i == N - 1); // [R1]
      logic [1:0] hist;
      logic need3;
      logic ftick;

      always_comb begin
        ftick = 1'b1;
        if (!FIXED) begin
          unique case (nc_reg[i]) // [R16]
            eif_pkg::NC_DIV1: ftick = 1'b1;
            eif_pkg::NC_DIV4: ftick = (pre_reg & eif_pkg::PRE_MASK4) == eif_pkg::PRE_MASK4;
            eif_pkg::NC_DIV8: ftick = (pre_reg & eif_pkg::PRE_MASK8) == eif_pkg::PRE_MASK8;
            eif_pkg::NC_DIV16: ftick = pre_reg == eif_pkg::PRE_MASK16;
          endcase
        end
      end
      assign need3 = fast && !FIXED; // [R8]
      assign tick[i] = run && (fast ? ftick : slow_tick); // [R18]

      always_ff @(posedge clk_i) begin
        if (rst_i) begin
          hist <= 2'h0;
          filt_reg[i] <= 1'b0; // [R21]
        end else if (tick[i]) begin
          hist <= {hist[0], sync2_reg[i]};
          if (need3 && hist == {2{sync2_reg[i]}}) begin
            filt_reg[i] <= sync2_reg[i]; // [R8] [R9]
          end else if (!need3 && hist[0] == sync2_reg[i]) begin
            filt_reg[i] <= sync2_reg[i]; // [R3] [R4] [R17]
          end
        end
      end

      always_comb begin
        ev[i] = 1'b0;
        if (run) begin
          if (FIXED) begin
            ev[i] = prev_reg[i] && !filt_reg[i]; // [R2]
          end else begin
            unique case (es_reg[i]) // [R5]
              eif_pkg::ES_RISE: ev[i] = filt_reg[i] && !prev_reg[i];
              eif_pkg::ES_FALL: ev[i] = prev_reg[i] && !filt_reg[i];
              eif_pkg::ES_BOTH: ev[i] = prev_reg[i] != filt_reg[i];
              eif_pkg::ES_HIGH: ev[i] = (i == 4) && filt_reg[i]; // [R6]
            endcase
          end
        end
      end

      if (FIXED) begin : gen_fixed_cfg
        assign nc_reg[i] = eif_pkg::NC_RESET;
        assign es_reg[i] = eif_pkg::ES_FALL;
        assign captured_level_reg[i] = 1'b0;
      end else begin : gen_cfg
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            nc_reg[i] <= eif_pkg::NC_RESET;
            es_reg[i] <= eif_pkg::ES_RESET;
          end else if (wr_en && wb_sel_i[0] && wb_adr_i == eif_pkg::OFS_CFG1 + 8'(4 * (i - 1))) begin
            nc_reg[i] <= wb_dat_i[eif_pkg::CFG_NC_LSB +: 2];
            es_reg[i] <= wb_dat_i[eif_pkg::CFG_ES_LSB +: 2];
          end
        end
        always_ff @(posedge clk_i) begin
          if (rst_i) begin
            captured_level_reg[i] <= 1'b0; // [R19]
          end else if (ev[i]) begin
            captured_level_reg[i] <= filt_reg[i]; // [R7] [R19]
          end
        end
      end
    end
  endgenerate

  // ==========================================================================
  // edge history and request output
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      prev_reg <= '0;
      irq_req_reg <= 6'h00;
    end else begin
      prev_reg <= filt_reg; // [R14]
      irq_req_reg <= ev & enable_reg & {N{master_irq_enable_reg}}; // [R10]
    end
  end

  assign irq_req_o = irq_req_reg;
  assign wb_ack_o = ack_reg;
  assign wb_dat_o = rdata_reg;

  // ==========================================================================
  // assertions
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_slow_tick;
    slow_tick;
  endsequence
  sequence s_quiet3;
    !slow_tick [*3];
  endsequence

  a_gate_after_reset: assert property ($past(rst_i) |-> !ext_irq_clock_gate_reg) // [R12]
    else $error("gate bit not cleared by reset");
  a_gate_blocks_req: assert property (!run |=> irq_req_o == 6'h00) // [R11] [R18]
    else $error("request while logic stopped");
  a_master_blocks: assert property (!master_irq_enable_reg |=> irq_req_o == 6'h00) // [R10]
    else $error("request while master enable clear");
  a_src0_falling: assert property (ev[0] |-> prev_reg[0] && !filt_reg[0]) // [R2]
    else $error("source zero fired without falling edge");
  a_fixed_two_samples: assert property (run && fast && $past(run && fast) && $stable(sync2_reg[5])
                                        |=> filt_reg[5] == $past(sync2_reg[5])) // [R3]
    else $error("fixed source missed stable level");
  a_reserved_silent: assert property (es_reg[1] == eif_pkg::ES_HIGH |-> !ev[1]) // [R5]
    else $error("reserved trigger code fired");
  a_high_level_trig: assert property (run && es_reg[4] == eif_pkg::ES_HIGH && filt_reg[4] |-> ev[4]) // [R6]
    else $error("high level trigger missed");
  a_level_capture: assert property (ev[2] |=> captured_level_reg[2] == $past(filt_reg[2])) // [R7]
    else $error("captured level not refreshed");
  a_three_equal: assert property ($past(run && fast) && $changed(filt_reg[1])
                                  |-> $past(gen_src[1].hist) == {2{filt_reg[1]}}) // [R8]
    else $error("configurable filter accepted early");
  a_slow_spacing: assert property (s_slow_tick |=> s_quiet3) // [R17]
    else $error("slow sample ticks too close");
  a_halt_no_tick: assert property (mode_reg == eif_pkg::EIF_HALT |-> tick == 6'h00) // [R18]
    else $error("sampling while halted");
endmodule // eif_top
`default_nettype wire

// File: testbench/eif_pin_model.sv
// board-side model driving the six external interrupt pins
`timescale 1ns/1ns
`default_nettype none
module eif_pin_model (
  input wire logic clk_i,
  output logic [5:0] pin_o
);
  // ==========================================
  // pin levels: source zero idles high, the rest idle low
  initial pin_o = 6'h01;
  // set a level for n whole cycles
  task drive(input int src, input logic lvl, input int n);
    @(posedge clk_i);
    pin_o[src] <= lvl;
    repeat (n - 1) @(posedge clk_i);
  endtask
  // pulse of w cycles, then back to the opposite level for settle cycles
  task pulse(input int src, input logic lvl, input int w, input int settle);
    drive(src, lvl, w);
    drive(src, ~lvl, settle);
  endtask
endmodule // eif_pin_model
`default_nettype wire

// File: testbench/ext_irq_noise_filter_edge_detect_tb_top.sv
// self-checking testbench of the external interrupt filter
`timescale 1ns/1ns
`default_nettype none
module ext_irq_noise_filter_edge_detect_tb_top;
  logic clk_i, rst_i, cyc, stb, we, ack;
  logic [7:0] adr;
  logic [3:0] sel;
  logic [31:0] wdat, rdat, q;
  logic [5:0] pin, irq;
  int cnt[6];
  int n_fail = 0;
  int n_compared = 0;
  // ==========================================
  // clock, reset, instances
  initial begin
    clk_i = 1'b0;
    forever #2 clk_i = ~clk_i;
  end
  initial begin
    rst_i = 1'b1; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; sel = 4'h0;
  end
  eif_pin_model pm (.clk_i(clk_i), .pin_o(pin));
  eif_top #(.LF_DIV(4)) dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .ext_irq_pin_zero_n_i(pin[0]), .ext_irq_pin_one_i(pin[1]), .ext_irq_pin_two_i(pin[2]),
    .ext_irq_pin_three_i(pin[3]), .ext_irq_pin_four_i(pin[4]), .ext_irq_pin_five_i(pin[5]),
    .irq_req_o(irq));
  always @(posedge clk_i) begin
    for (int i = 0; i < 6; i++) if (irq[i] === 1'b1) cnt[i]++;
  end
  // ==========================================
  // helpers
  task clr();
    for (int i = 0; i < 6; i++) cnt[i] = 0;
  endtask
  task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", nm, exp, got);
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_i);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d; sel <= 4'hF;
    do @(posedge clk_i); while (ack !== 1'b1);
    r = rdat;
    cyc <= 1'b0; stb <= 1'b0;
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d, q);
  endtask
  task give_verdict();
    if (n_fail == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========================================
  // scenarios
  task t_reset();
    wb(1'b0, eif_pkg::OFS_CTRL, 32'h0, q); chk("ctrl", 32'h0, q);
    wb(1'b0, eif_pkg::OFS_CFG4, 32'h0, q); chk("cfg4", 32'h0, q);
    wb(1'b0, eif_pkg::OFS_STAT, 32'h0, q); chk("stat", 32'h0, q);
    wb(1'b0, 8'h1C, 32'h0, q); chk("unmapped", 32'h0, q);
  endtask
  task t_gate();
    wr(eif_pkg::OFS_CTRL, 32'h3F02);
    clr(); pm.pulse(1, 1'b1, 20, 40); chk("gated", 32'h0, cnt[1]);
    wr(eif_pkg::OFS_CTRL, 32'h0001);
    repeat (40) @(posedge clk_i);
    wr(eif_pkg::OFS_CTRL, 32'h3F03);
  endtask
  task t_fixed();
    clr(); pm.pulse(0, 1'b0, 5, 30); chk("src0", 32'h1, cnt[0]);
    pm.pulse(5, 1'b1, 5, 30); chk("src5", 32'h1, cnt[5]);
    wb(1'b0, eif_pkg::OFS_STAT, 32'h0, q); chk("stat", 32'h01, q);
  endtask
  task t_trig();
    logic [3:0] re, fe;
    re = 4'h5; fe = 4'h6;
    for (int s = 1; s < 5; s++) for (int c = 0; c < 4; c++) begin
      wr(eif_pkg::OFS_CFG1 + 8'(4 * (s - 1)), 32'(c << eif_pkg::CFG_ES_LSB));
      clr(); pm.drive(s, 1'b1, 30);
      if (s == 4 && c == 3) chk("high", 32'h1, 32'(cnt[4] > 1));
      else chk("rise", 32'(re[c]), cnt[s]);
      wb(1'b0, eif_pkg::OFS_CFG1 + 8'(4 * (s - 1)), 32'h0, q);
      if (re[c]) chk("lvl1", 32'h1, 32'(q[eif_pkg::CFG_LVL_BIT]));
      clr(); pm.drive(s, 1'b0, 30);
      if (c != 3) chk("fall", 32'(fe[c]), cnt[s]);
      wb(1'b0, eif_pkg::OFS_CFG1 + 8'(4 * (s - 1)), 32'h0, q);
      if (fe[c]) chk("lvl0", 32'h0, 32'(q[eif_pkg::CFG_LVL_BIT]));
    end
  endtask
  task t_filt();
    int nc[8];
    int w[8];
    nc = '{0, 0, 1, 1, 2, 2, 3, 3};
    w = '{1, 5, 6, 14, 14, 26, 30, 50};
    for (int i = 0; i < 8; i++) begin
      wr(eif_pkg::OFS_CFG1, 32'(nc[i]));
      clr(); pm.pulse(1, 1'b1, w[i], 80);
      chk("filter", 32'(i % 2), cnt[1]);
    end
  endtask
  task t_mask();
    logic [31:0] c[3];
    c = '{32'h3F01, 32'h3D03, 32'h3F03};
    wr(eif_pkg::OFS_CFG1, 32'h0);
    for (int i = 0; i < 3; i++) begin
      wr(eif_pkg::OFS_CTRL, c[i]);
      clr(); pm.pulse(1, 1'b1, 30, 40);
      chk("mask", 32'(i / 2), cnt[1]);
    end
  endtask
  task t_slow();
    wr(eif_pkg::OFS_CTRL, 32'h0003);
    wr(eif_pkg::OFS_MODE, 32'h1);
    pm.drive(5, 1'b1, 80);
    wr(eif_pkg::OFS_CTRL, 32'h2003);
    clr(); pm.pulse(5, 1'b0, 12, 100); chk("slow short", 32'h0, cnt[5]);
    pm.pulse(5, 1'b0, 40, 100); chk("slow long", 32'h1, cnt[5]);
    wr(eif_pkg::OFS_CTRL, 32'h0003);
    wr(eif_pkg::OFS_MODE, 32'h2);
    wb(1'b0, eif_pkg::OFS_MODE, 32'h0, q); chk("mode", 32'h2, q);
    repeat (48) @(posedge clk_i);
    wr(eif_pkg::OFS_CTRL, 32'h2003);
    clr(); pm.pulse(5, 1'b0, 40, 100); chk("halted", 32'h0, cnt[5]);
  endtask
  // ==========================================
  // main sequence and watchdog
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_gate();
    t_fixed();
    t_trig();
    t_filt();
    t_mask();
    t_slow();
    give_verdict();
  end
  initial begin
    #100000;
    n_fail++;
    give_verdict();
  end
endmodule // ext_irq_noise_filter_edge_detect_tb_top
`default_nettype wire
